// ==== rtl/adsq_defs.vh ====
/*
 * Register offsets, field positions, reset values and timing counts for
 * the four-channel converter sequencer. Assumes a 125 MHz system clock.
 */
`ifndef ADSQ_DEFS_VH
`define ADSQ_DEFS_VH

`define ADSQ_OFS_CONTROL   8'h00
`define ADSQ_OFS_PINCFG    8'h04
`define ADSQ_OFS_RESULT    8'h08
`define ADSQ_OFS_INTSTAT   8'h0C
`define ADSQ_OFS_INTMASK   8'h10
`define ADSQ_OFS_PORTIN    8'h14

`define ADSQ_CTL_RESET     8'h00
`define ADSQ_PORT_ANALOG_CONFIG_RESET    3'h0

`define ADSQ_BIT_POWER     0
`define ADSQ_BIT_GO        2
`define ADSQ_BIT_DONE      6
`define ADSQ_BIT_PINCHG    0
`define ADSQ_BIT_EXTINT    1

// clk_sys cycles per conversion bit; two at least, since dac_code
// trails the trial code by one cycle and a faster step compares stale codes
`define ADSQ_DIV_OSC2      8'h02
`define ADSQ_DIV_OSC8      8'h08
`define ADSQ_DIV_OSC32     8'h20
`define ADSQ_DIV_RC        8'hFA
`define ADSQ_SAR_BITS      4'h8

`endif

// ==== rtl/adsq_sar.v ====
/*
 * Eight-bit successive-approximation engine.
 * Assumes a comparator result from the analog core, valid one bit period
 * after each trial code is driven; steps on a one-cycle enable.
 */
`timescale 1ns/100ps
`default_nettype none
module adsq_sar #(
	parameter WIDTH = 8
) (
	// clock and reset
	input  wire             clk_sys,
	input  wire             sys_rst,
	// control
	input  wire             start,
	input  wire             abort,
	input  wire             bit_tick,
	input  wire             cmp_high,
	// results
	output reg  [WIDTH-1:0] trial,
	output reg  [WIDTH-1:0] result,
	output reg              busy,
	output reg              done
);
	reg [WIDTH-1:0] mask;

	always @(posedge clk_sys) begin
		done <= 1'b0;
		if (sys_rst || abort) begin
			trial  <= {WIDTH{1'b0}};
			mask   <= {WIDTH{1'b0}};
			busy   <= 1'b0;
			if (sys_rst)
				result <= {WIDTH{1'b0}};
		end else if (start && !busy) begin
			mask  <= {1'b1, {(WIDTH-1){1'b0}}};
			trial <= {1'b1, {(WIDTH-1){1'b0}}};
			busy  <= 1'b1;
		end else if (busy && bit_tick) begin
			// keep the trial bit when the held sample is above it
			if (mask == {{(WIDTH-1){1'b0}}, 1'b1}) begin
				result <= cmp_high ? trial : (trial & ~mask);
				busy   <= 1'b0;
				done   <= 1'b1;
			end else begin
				trial <= (cmp_high ? trial : (trial & ~mask)) | (mask >> 1);
				mask  <= mask >> 1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== rtl/adsq_top.v ====
/*
 * Four-channel 8-bit converter sequencer with AHB-Lite register slave,
 * clock-rate selection, pin analog/digital masking and completion interrupt.
 * Assumes an analog core that samples the selected input and returns a
 * comparator bit; port pins arrive asynchronously and are synchronised.
 */
`timescale 1ns/100ps
`default_nettype none
`include "adsq_defs.vh"

// Notes on behaviour
// - clock select: osc/2, /8, /32, rc
// - channel codes pick pins 0,1,2,4
// - go starts conversion, reads 1 while busy
// - end: load result, clear go, set flag
// - power bit low shuts converter off
// - eight-bit successive approximation from sample hold
// - pin config sets analog pins and reference
// - analog-configured pins read as zero
// - config write may raise pin-change, external flags
// - conversion continues through device sleep
// - control bits 5 and 1 reserved read/write
module adsq_top #(
	parameter RC_DIV = 250
) (
	// clock and reset
	input  wire        clk_sys,
	input  wire        sys_rst,
	// ahb-lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	// analog core
	input  wire        cmp_high,
	output reg  [2:0]  sample_pin,
	output reg  [7:0]  dac_code,
	output reg         sample_hold,
	output reg         core_enable,
	output reg         ref_ext,
	output reg  [3:0]  pin_analog,
	// port pins and system
	input  wire [3:0]  port_pins,
	input  wire        sleep_mode,
	output reg         irq
);
	reg  [7:0]  adc_control;
	reg  [2:0]  port_analog_config;
	reg  [7:0]  conversion_result_reg;
	reg  [6:0]  int_status;
	reg  [6:0]  int_mask;
	reg  [3:0]  pin_meta;
	reg  [3:0]  pin_sync;
	reg  [7:0]  div_cnt;
	reg         bit_tick;
	reg         wr_pend;
	reg  [7:0]  wr_addr;
	reg         go_req;
	reg  [7:0]  div_sel;
	reg  [3:0]  next_analog;
	wire [7:0]  sar_trial;
	wire [7:0]  sar_result;
	wire        sar_busy;
	wire        sar_done;
	wire        addr_phase;
	wire        powered;

	assign addr_phase = hsel && hready && htrans[1];
	assign powered    = adc_control[`ADSQ_BIT_POWER];

	// conversion clock divider; control bits 7:6 alone pick the rate, sleep included
	always @* begin
		case (adc_control[7:6])
			2'b00:   div_sel = `ADSQ_DIV_OSC2;
			2'b01:   div_sel = `ADSQ_DIV_OSC8;
			2'b10:   div_sel = `ADSQ_DIV_OSC32;
			default: div_sel = RC_DIV[7:0];
		endcase
	end

	always @(posedge clk_sys) begin
		if (sys_rst || !sar_busy) begin
			div_cnt  <= 8'h00;
			bit_tick <= 1'b0;
		end else if (div_cnt >= div_sel - 8'h01) begin
			div_cnt  <= 8'h00;
			bit_tick <= 1'b1;
		end else begin
			div_cnt  <= div_cnt + 8'h01;
			bit_tick <= 1'b0;
		end
	end

	// sleep_mode gates nothing here: a running conversion finishes
	wire unused_sleep = sleep_mode;

	// pin analog map
	always @* begin
		case (port_analog_config)
			3'h0, 3'h1:  next_analog = 4'hF;
			3'h2, 3'h3:  next_analog = 4'h7;
			3'h4, 3'h5:  next_analog = 4'h3;
			3'h6:        next_analog = 4'h1;
			default:     next_analog = 4'h0;
		endcase
	end

	// ahb-lite: writes finish in the data phase, zero wait states
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			wr_pend   <= 1'b0;
			wr_addr   <= 8'h00;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_pend   <= addr_phase && hwrite;
			wr_addr   <= haddr[7:0];
			hrdata    <= 32'h0000_0000;
			if (addr_phase && !hwrite) begin
				if (haddr[7:0] == `ADSQ_OFS_CONTROL)
					hrdata <= {24'h0, adc_control[7:3], sar_busy | adc_control[2],
						adc_control[1:0]};
				else if (haddr[7:0] == `ADSQ_OFS_PINCFG)
					hrdata <= {29'h0, port_analog_config};
				else if (haddr[7:0] == `ADSQ_OFS_RESULT)
					hrdata <= {24'h0, conversion_result_reg};
				else if (haddr[7:0] == `ADSQ_OFS_INTSTAT)
					hrdata <= {25'h0, int_status};
				else if (haddr[7:0] == `ADSQ_OFS_INTMASK)
					hrdata <= {25'h0, int_mask};
				else if (haddr[7:0] == `ADSQ_OFS_PORTIN)
					hrdata <= {28'h0, pin_sync & ~pin_analog};
			end
		end
	end

	// control, config and interrupt registers
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			adc_control           <= `ADSQ_CTL_RESET;
			port_analog_config    <= `ADSQ_PORT_ANALOG_CONFIG_RESET;
			conversion_result_reg <= 8'h00;
			int_status            <= 7'h00;
			int_mask              <= 7'h00;
			go_req                <= 1'b0;
			pin_meta              <= 4'h0;
			pin_sync              <= 4'h0;
			pin_analog            <= 4'hF;
			ref_ext               <= 1'b0;
			irq                   <= 1'b0;
		end else begin
			pin_meta   <= port_pins;
			pin_sync   <= pin_meta;
			pin_analog <= next_analog;
			ref_ext    <= (port_analog_config == 3'h1) || (port_analog_config == 3'h3)
				|| (port_analog_config == 3'h5);
			go_req     <= 1'b0;
			irq        <= |(int_status & int_mask);
			if (wr_pend && wr_addr == `ADSQ_OFS_CONTROL) begin
				adc_control <= hwdata[7:0];
				// go while off is dropped
				if (!hwdata[`ADSQ_BIT_POWER])
					adc_control[`ADSQ_BIT_GO] <= 1'b0;
				else
					go_req <= hwdata[`ADSQ_BIT_GO] & ~sar_busy;
			end
			if (wr_pend && wr_addr == `ADSQ_OFS_PINCFG)
				port_analog_config <= hwdata[2:0];
			if (wr_pend && wr_addr == `ADSQ_OFS_INTMASK)
				int_mask <= hwdata[6:0];
			if (wr_pend && wr_addr == `ADSQ_OFS_INTSTAT)
				int_status <= int_status & ~hwdata[6:0];
			// hardware sets win over software clears
			if (wr_pend && wr_addr == `ADSQ_OFS_PINCFG && hwdata[2:0] != port_analog_config) begin
				int_status[`ADSQ_BIT_PINCHG] <= 1'b1;
				int_status[`ADSQ_BIT_EXTINT] <= 1'b1;
			end
			if (sar_done) begin
				conversion_result_reg  <= sar_result;
				adc_control[`ADSQ_BIT_GO] <= 1'b0;
				int_status[`ADSQ_BIT_DONE] <= 1'b1;
			end
			if (!powered && !(wr_pend && wr_addr == `ADSQ_OFS_CONTROL))
				adc_control[`ADSQ_BIT_GO] <= 1'b0;
		end
	end

	// analog core drive
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			sample_pin  <= 3'h0;
			dac_code    <= 8'h00;
			sample_hold <= 1'b0;
			core_enable <= 1'b0;
		end else begin
			case (adc_control[4:3])
				2'b00:   sample_pin <= 3'h0;
				2'b01:   sample_pin <= 3'h1;
				2'b10:   sample_pin <= 3'h2;
				default: sample_pin <= 3'h4;
			endcase
			dac_code    <= sar_trial;
			sample_hold <= sar_busy;
			core_enable <= powered;
		end
	end

	adsq_sar #(
		.WIDTH(8)
	) u_sar (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.start    (go_req),
		.abort    (!powered),
		.bit_tick (bit_tick),
		.cmp_high (cmp_high),
		.trial    (sar_trial),
		.result   (sar_result),
		.busy     (sar_busy),
		.done     (sar_done)
	);
endmodule
`default_nettype wire

// ==== tb/adsq_props.sv ====
/* Port checker for adsq_top. Bound from the bench top file by name. */
`timescale 1ns/100ps
`default_nettype none
module adsq_props (
	// bus side
	input	wire logic		clk_sys,
	input	wire logic		sys_rst,
	input	wire logic		hsel,
	input	wire logic [31:0]	haddr,
	input	wire logic [1:0]	htrans,
	input	wire logic		hwrite,
	input	wire logic [31:0]	hwdata,
	input	wire logic [31:0]	hrdata,
	// converter side
	input	wire logic [2:0]	sample_pin,
	input	wire logic		sample_hold,
	input	wire logic		core_enable,
	input	wire logic		ref_ext,
	input	wire logic [3:0]	pin_analog
);
	logic		wc;
	logic		wp;
	logic [7:0]	d;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// flags mark the data phase of a control or pin config write
	always_ff @(posedge clk_sys) begin
		wc <= !sys_rst && hsel && htrans[1] && hwrite && haddr == 32'h0;
		wp <= !sys_rst && hsel && htrans[1] && hwrite && haddr == 32'h4;
		if (wc || wp) begin
			d <= hwdata[7:0];
		end
	end
	property p_pwr; wc |=> ##[0:1] core_enable == d[0]; endproperty
	a_pwr: assert property (p_pwr) else $error("power bit ignored");
	property p_sel; wc |=> ##[0:1] sample_pin == (d[4:3] == 2'h3 ? 3'h4 : {1'h0, d[4:3]}); endproperty
	a_sel: assert property (p_sel) else $error("wrong pin");
	property p_ref;
		wp |=> ##[0:1] ref_ext == (d[0] && d[2:0] != 3'h7) && pin_analog[3] == (d[2:0] < 3'h2)
			&& pin_analog[2] == (d[2:0] < 3'h4) && pin_analog[0] == (d[2:0] != 3'h7);
	endproperty
	a_ref: assert property (p_ref) else $error("pin config wrong");
	property p_len; $rose(sample_hold) |-> sample_hold[*8]; endproperty
	a_len: assert property (p_len) else $error("conversion too short");
	property p_start; $rose(sample_hold) |-> core_enable; endproperty
	a_start: assert property (p_start) else $error("start while off");
	property p_off; $fell(core_enable) |-> ##[0:2] !sample_hold; endproperty
	a_off: assert property (p_off) else $error("no abort on power off");
	property p_rst; disable iff (1'h0) sys_rst |=> pin_analog == 4'hF && !sample_hold; endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	property p_port;
		hsel && htrans[1] && !hwrite && haddr == 32'h14
			|=> (hrdata[3:0] & pin_analog & $past(pin_analog)) == 4'h0;
	endproperty
	a_port: assert property (p_port) else $error("analog pin reads one");
	c_conv: cover property ($fell(sample_hold));
	c_cfg: cover property (wp);
	c_ref: cover property (ref_ext);
endmodule
`default_nettype wire

// ==== tb/adsq_analog_model.sv ====
/* Analog front end model: pin levels and comparator. Shares clk_sys. */
`timescale 1ns/100ps
`default_nettype none
module adsq_analog_model (
	// clock
	input	wire logic		clk_sys,
	// converter side
	input	wire logic [2:0]	sample_pin,
	input	wire logic [7:0]	dac_code,
	input	wire logic		sample_hold,
	// one byte per pin: 4, 2, 1, 0
	input	wire logic [31:0]	levels,
	output	var logic		cmp_high
);
	logic [7:0]	v;
	logic		tgl = 1'h0;
	// levels sit mid-code, so equal counts as above
	assign v = levels[{sample_pin[2] ? 2'h3 : sample_pin[1:0], 3'h0} +: 8];
	always @(posedge clk_sys) begin
		tgl <= !tgl;
	end
	// no hold, no valid compare: keep it moving
	assign cmp_high = sample_hold ? v >= dac_code : tgl;
endmodule
`default_nettype wire

// ==== tb/adsq_top_test.sv ====
/* Self-checking bench for adsq_top. Uses adsq_props and adsq_analog_model. */
`timescale 1ns/100ps
`default_nettype none
module adsq_top_test;
	localparam int	RCD = 20;
	logic		clk_sys = 1'h0;
	logic		sys_rst = 1'h1;
	logic		hsel = 1'h0;
	logic [31:0]	haddr = 32'h0;
	logic [1:0]	htrans = 2'h0;
	logic		hwrite = 1'h0;
	logic [2:0]	hsize = 3'h2;
	logic [31:0]	hwdata = 32'h0;
	logic [3:0]	port_pins = 4'h0;
	logic		sleep_mode = 1'h0;
	logic [31:0]	levels = 32'h0;
	logic		rd_dp = 1'h0;
	logic [15:0]	rs = 16'hFF74;
	logic [63:0]	q[$];
	int		n_mismatch = 0;
	int		checked = 0;
	int		cyc = 0;
	int		hn = 0;
	logic [31:0]	hrdata;
	logic		hreadyout;
	logic		hresp;
	logic [2:0]	sample_pin;
	logic [7:0]	dac_code;
	logic		sample_hold;
	logic		irq;
	logic		cmp_high;
	adsq_top #(.RC_DIV(RCD)) u_adsq_top (.*, .hready(hreadyout), .core_enable(),
		.ref_ext(), .pin_analog());
	adsq_analog_model u_adsq_analog_model (.*);
	initial begin
		forever #4 clk_sys = !clk_sys;
	end
	function automatic logic [15:0] rnd();
		rs = rs ^ (rs << 7);
		rs = rs ^ (rs >> 9);
		rs = rs ^ (rs << 8);
		return rs;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [63:0] e);
		checked++;
		if ((got & e[63:32]) !== e[31:0]) begin
			n_mismatch++;
			$display("[ERR] %0t got %h want %h", $time, got, e[31:0]);
		end
	endtask
	task automatic report_and_stop();
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// reads queue their note; the monitor below compares
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [63:0] e);
		@(posedge clk_sys);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge clk_sys);
		while (hreadyout !== 1'h1) @(posedge clk_sys);
		htrans <= 2'h0;
		hwdata <= d;
		rd_dp <= !w;
		if (!w) q.push_back(e);
		@(posedge clk_sys);
		while (hreadyout !== 1'h1) @(posedge clk_sys);
		rd_dp <= 1'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'h1, a, d, 64'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		xfer(1'h0, a, 32'h0, {m, e});
	endtask
	task automatic ci(input logic e);
		repeat (2) @(posedge clk_sys);
		chk({31'h0, irq}, {32'h1, 31'h0, e});
	endtask
	always @(posedge clk_sys) begin
		if (rd_dp && hreadyout === 1'h1) begin
			chk(hrdata, q.pop_front());
			chk({31'h0, hresp}, 64'h0000000100000000);
		end
		if (sample_hold === 1'h1) hn <= hn + 1;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	initial begin
		logic [15:0] r;
		logic [1:0] ch;
		int dv;
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'h0;
		rd(8'h00, 32'hFF, 32'h0);
		rd(8'h04, 32'hFF, 32'h0);
		rd(8'h18, 32'hFFFFFFFF, 32'h0);
		wr(8'h00, 32'h26);
		rd(8'h00, 32'hFF, 32'h22);
		for (int c = 0; c < 8; c++) begin
			r = rnd();
			port_pins <= r[3:0];
			wr(8'h04, {r, 13'h0, c[2:0]});
			rd(8'h04, 32'hFF, c);
			rd(8'h14, 32'hF, {28'h0, r[3:0] & ~{c < 2, c < 4, c < 6, c != 7}});
		end
		wr(8'h04, 32'h0);
		rd(8'h0C, 32'h3, 32'h3);
		ci(1'h0);
		wr(8'h10, 32'h1);
		ci(1'h1);
		wr(8'h0C, 32'h3);
		ci(1'h0);
		wr(8'h10, 32'h40);
		for (int k = 0; k < 4; k++) begin
			r = rnd();
			levels <= {r, ~r};
			ch = r[9:8];
			dv = k == 0 ? 2 : k == 1 ? 8 : k == 2 ? 32 : RCD;
			sleep_mode <= k == 3;
			wr(8'h00, {24'h0, k[1:0], 1'h0, ch, 3'h1});
			repeat (8) @(posedge clk_sys);
			hn <= 0;
			wr(8'h00, {24'h0, k[1:0], 1'h0, ch, 3'h5});
			rd(8'h00, 32'h4, 32'h4);
			while (sample_hold === 1'h1) @(posedge clk_sys);
			chk(32'(hn >= 8 * dv && hn <= 8 * dv + 8), 64'h0000000100000001);
			rd(8'h00, 32'hFF, {24'h0, k[1:0], 1'h0, ch, 3'h1});
			rd(8'h08, 32'hFF, levels[ch * 8 +: 8]);
			rd(8'h0C, 32'h40, 32'h40);
			ci(1'h1);
			repeat (2 * dv) @(posedge clk_sys);
		end
		sleep_mode <= 1'h0;
		wr(8'h0C, 32'h40);
		ci(1'h0);
		wr(8'h00, 32'h85);
		repeat (20) @(posedge clk_sys);
		wr(8'h00, 32'h0);
		rd(8'h00, 32'hFF, 32'h0);
		rd(8'h0C, 32'h40, 32'h0);
		report_and_stop();
	end
endmodule
bind adsq_top adsq_props u_adsq_props (.*);
`default_nettype wire
